// ===== verilog/rcp_pkg.sv
// Constants, types and helpers for the receive cell processor
// Behaviour
// - Flush control empties FIFO and drops writes
// - Descramble payload unless disable bit set
// - Optionally add coset to received HCS
// - Drop uncorrectable cells unless pass-through
// - Pass-through forwards errored cells, stays correcting
// - Drop all cells outside SYNC
// - Correct single-bit header errors when enabled
// - Correction disabled makes errors uncorrectable
// - Drop idle cells unless filter bypassed
// - Bypass ignores pattern, no zero-VPI/VCI filtering
// - Parity over output byte, even or odd
// - Status bit high outside SYNC
// - Overrun flag, cleared by status read
// - Uncorrectable header flag, cleared by read
// - Correctable header flag, cleared by read
// - Delineation change flag, cleared by read
// - Each event interrupts only when enabled
// - Pattern maps to GFC, PTI, CLP positions
// - Idle needs zero VPI/VCI plus pattern
// - Mask bit one compares, zero ignores
package rcp_pkg;
   localparam logic [7:0] IDX_CTRL  = 8'h50;
   localparam logic [7:0] IDX_IRQ   = 8'h51;
   localparam logic [7:0] IDX_PAT   = 8'h52;
   localparam logic [7:0] IDX_MSK   = 8'h53;
   localparam logic [7:0] CTRL_RST  = 8'h04;
   localparam logic [7:0] COSET     = 8'h55;
   localparam logic [7:0] CRC_POLY  = 8'h07;
   localparam logic [5:0] HCS_POS   = 6'h04;
   localparam logic [5:0] PAY_POS   = 6'h05;
   localparam logic [5:0] LAST_POS  = 6'h34;
   localparam logic [5:0] TAIL_OFS  = 6'h30;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int SCR_LEN   = 43;
   localparam int CELL_LEN  = 53;
   localparam int ALPHA_DEF = 7;
   localparam int DELTA_DEF = 6;
   localparam int CELLS_DEF = 4;
   localparam int B_OOC     = 7;
   localparam int F_OV      = 0;
   localparam int F_UH      = 1;
   localparam int F_CH      = 2;
   localparam int F_DC      = 3;

   typedef struct packed {
      logic parity_type;
      logic filter_bypass;
      logic corr_dis;
      logic hdr_pass;
      logic coset_add;
      logic descr_dis;
      logic flush;
   } rcp_ctrl_s;

   typedef struct packed {
      logic [3:0] gfc;
      logic [2:0] pti;
      logic       clp;
   } rcp_hsel_s;

   typedef enum logic [2:0] {HUNT = 3'h1, PRESYNC = 3'h2, SYNC = 3'h4} rcp_delin_e;
   typedef enum logic [1:0] {CORRECT = 2'h1, DETECT = 2'h2} rcp_hcsm_e;

   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   // Error pattern for a single-bit syndrome, zero when none fits
   function automatic logic [39:0] syn_mask(input logic [7:0] s);
      logic [39:0] v;
      logic [39:0] m;
      m = 40'h0;
      for (int i = 0; i < 40; i++) begin
         v = 40'h1 << i;
         if (s != 8'h00 && (crc8(v[39:8]) ^ v[7:0]) == s) m = v;
      end
      return m;
   endfunction

   // Self-synchronous x^43+1 descrambler, bits taken msb first
   function automatic logic [SCR_LEN+7:0] descr(input logic [7:0] b,
                                                input logic [SCR_LEN-1:0] h);
      logic [7:0]         o;
      logic [SCR_LEN-1:0] n;
      n = h;
      o = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         o[i] = b[i] ^ n[SCR_LEN-1];
         n = {n[SCR_LEN-2:0], b[i]};
      end
      return {o, n};
   endfunction
endpackage

// ===== verilog/rcp_receive_cell_processor.sv
// Receive cell processor: delineation, HCS check, filter, cell FIFO, registers
module rcp_receive_cell_processor #(
   parameter int AW    = 12,
   parameter int CELLS = rcp_pkg::CELLS_DEF,
   parameter int ALPHA = rcp_pkg::ALPHA_DEF,
   parameter int DELTA = rcp_pkg::DELTA_DEF
) (
   input  wire logic          aclk,          // System clock
   input  wire logic          aresetn,       // Synchronous reset, low
   input  wire logic [AW-1:0] awaddr,        // Write address
   input  wire logic          awvalid,       // Write address valid
   output logic               awready,       // Write address ready
   input  wire logic [31:0]   wdata,         // Write data
   input  wire logic [3:0]    wstrb,         // Write strobes
   input  wire logic          wvalid,        // Write data valid
   output logic               wready,        // Write data ready
   output logic [1:0]         bresp,         // Write response
   output logic               bvalid,        // Write response valid
   input  wire logic          bready,        // Write response ready
   input  wire logic [AW-1:0] araddr,        // Read address
   input  wire logic          arvalid,       // Read address valid
   output logic               arready,       // Read address ready
   output logic [31:0]        rdata,         // Read data
   output logic [1:0]         rresp,         // Read response
   output logic               rvalid,        // Read data valid
   input  wire logic          rready,        // Read data ready
   input  wire logic          in_valid,      // Payload envelope byte valid
   input  wire logic [7:0]    in_data,       // Payload envelope byte
   input  wire logic          rx_read,       // Read one FIFO byte
   output logic               rx_cell_avail, // Whole cell in FIFO
   output logic [7:0]         rx_data_out,   // Received byte
   output logic               rx_data_valid, // Byte valid pulse
   output logic               rx_cell_start, // First byte of cell
   output logic               rx_parity_out, // Parity over byte
   output logic               irq            // Interrupt, high active
);
   import rcp_pkg::*;

   localparam int PW = (CELLS > 1) ? $clog2(CELLS) : 1;
   localparam int CW = $clog2(CELLS + 1);
   localparam int MW = $clog2(CELLS * CELL_LEN);

   function automatic logic [3:0] dec(input logic [AW-1:0] a);
      logic [AW-3:0] w;
      w = a[AW-1:2];
      dec = 4'h0;
      if (a[1:0] == 2'h0) begin
         dec[0] = (w == (AW-2)'(IDX_CTRL));
         dec[1] = (w == (AW-2)'(IDX_IRQ));
         dec[2] = (w == (AW-2)'(IDX_PAT));
         dec[3] = (w == (AW-2)'(IDX_MSK));
      end
   endfunction

   // Register bus state
   rcp_ctrl_s     ctrl, next_ctrl;
   rcp_hsel_s     pat, next_pat, msk, next_msk;
   logic [2:0]    ien, next_ien;
   logic [3:0]    flags, next_flags;
   logic          aw_got, next_aw_got, w_got, next_w_got;
   logic [AW-1:0] aw_a, next_aw_a;
   logic [7:0]    w_d, next_w_d;
   logic          w_s, next_w_s;
   logic          next_bvalid, next_rvalid;
   logic [1:0]    next_bresp, next_rresp;
   logic [31:0]   next_rdata;
   logic [3:0]    rsel, wsel, ev;
   logic          rd_irq, ooc;

   // Cell path state
   rcp_delin_e         dstate, next_dstate;
   rcp_hcsm_e          hstate, next_hstate;
   logic [5:0]         idx, next_idx, dpos;
   logic [2:0]         run, next_run;
   logic [39:0]        win, next_win, nwin, emask, dly, next_dly;
   logic [SCR_LEN-1:0] shist, next_shist;
   logic [SCR_LEN+7:0] dsc;
   logic [31:0]        fix, next_fix, hfix;
   logic               acc, next_acc;
   logic [7:0]         syn, wbyte;
   logic               at_hdr, sync_hdr, hdr_ok, corr, unc, keep, idle, cand;

   // FIFO state
   logic [7:0]    mem [CELLS*CELL_LEN];
   logic [PW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [CW-1:0] cnt, next_cnt;
   logic [5:0]    rbyte, next_rbyte;
   logic          wr, commit, rd, pop;
   logic [CW-1:0] held;
   logic [7:0]    next_rx_data;
   logic          next_rx_valid, next_rx_start, next_rx_par;

   assign awready = !aw_got;
   assign wready  = !w_got;
   assign arready = !rvalid;
   assign rsel    = dec(araddr);
   assign wsel    = dec(aw_a);
   assign rd_irq  = arvalid && arready && rsel[1];
   assign ooc     = (dstate != SYNC);
   // Shared header-error enable covers both HCS flags
   assign irq = |(flags & {ien[2], ien[1], ien[1], ien[0]});

   always_comb begin
      next_ctrl   = ctrl;
      next_pat    = pat;
      next_msk    = msk;
      next_ien    = ien;
      next_aw_got = aw_got;
      next_aw_a   = aw_a;
      next_w_got  = w_got;
      next_w_d    = w_d;
      next_w_s    = w_s;
      next_bvalid = bvalid && !bready;
      next_bresp  = bresp;
      next_rvalid = rvalid && !rready;
      next_rresp  = rresp;
      next_rdata  = rdata;
      if (awvalid && awready) begin
         next_aw_got = 1'b1;
         next_aw_a   = awaddr;
      end
      if (wvalid && wready) begin
         next_w_got = 1'b1;
         next_w_d   = wdata[7:0];
         next_w_s   = wstrb[0];
      end
      if (aw_got && w_got && !bvalid) begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = (wsel != 4'h0) ? RESP_OKAY : RESP_SLVERR;
         if (w_s && wsel[0]) next_ctrl = rcp_ctrl_s'(w_d[6:0]);
         if (w_s && wsel[1]) next_ien = w_d[7:5];
         if (w_s && wsel[2]) next_pat = rcp_hsel_s'(w_d);
         if (w_s && wsel[3]) next_msk = rcp_hsel_s'(w_d);
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = (rsel != 4'h0) ? RESP_OKAY : RESP_SLVERR;
         next_rdata  = 32'h0;
         if (rsel[0]) next_rdata[7:0] = {ooc, ctrl};
         if (rsel[1]) next_rdata[7:0] = {ien, flags, 1'b0};
         if (rsel[2]) next_rdata[7:0] = pat;
         if (rsel[3]) next_rdata[7:0] = msk;
      end
      // A new event in the clearing cycle survives the read
      next_flags = (flags & ~{4{rd_irq}}) | ev;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl   <= rcp_ctrl_s'(CTRL_RST[6:0]);
         pat    <= rcp_hsel_s'(8'h00);
         msk    <= rcp_hsel_s'(8'h00);
         ien    <= 3'h0;
         flags  <= 4'h0;
         aw_got <= 1'b0;
         aw_a   <= '0;
         w_got  <= 1'b0;
         w_d    <= 8'h00;
         w_s    <= 1'b0;
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp  <= RESP_OKAY;
         rdata  <= 32'h0;
      end else begin
         ctrl   <= next_ctrl;
         pat    <= next_pat;
         msk    <= next_msk;
         ien    <= next_ien;
         flags  <= next_flags;
         aw_got <= next_aw_got;
         aw_a   <= next_aw_a;
         w_got  <= next_w_got;
         w_d    <= next_w_d;
         w_s    <= next_w_s;
         bvalid <= next_bvalid;
         bresp  <= next_bresp;
         rvalid <= next_rvalid;
         rresp  <= next_rresp;
         rdata  <= next_rdata;
      end
   end

   // Header check over the last five bytes, including the one arriving now
   always_comb begin
      nwin     = {win[31:0], in_data};
      syn      = crc8(nwin[39:8]) ^ nwin[7:0] ^ (ctrl.coset_add ? COSET : 8'h00);
      emask    = syn_mask(syn);
      hdr_ok   = (syn == 8'h00);
      at_hdr   = in_valid && (dstate == HUNT || idx == HCS_POS);
      sync_hdr = in_valid && dstate == SYNC && idx == HCS_POS;
      corr     = !hdr_ok && emask != 40'h0 && !ctrl.corr_dis && hstate == CORRECT;
      unc      = !hdr_ok && !corr;
      keep     = hdr_ok || corr || ctrl.hdr_pass;
      hfix     = nwin[39:8] ^ (corr ? emask[39:8] : 32'h0);
      // VPI and VCI all zero, then masked GFC/PTI/CLP against the pattern
      idle     = (hfix[27:4] == 24'h0)
                 && (((rcp_hsel_s'({hfix[31:28], hfix[3:0]}) ^ pat) & msk) == 8'h00);
      cand     = sync_hdr && keep && !(idle && !ctrl.filter_bypass) && !ctrl.flush;
      dsc      = descr(in_data, shist);
      ev       = 4'h0;
      next_dstate = dstate;
      next_hstate = hstate;
      next_idx    = idx;
      next_run    = run;
      next_win    = win;
      next_dly    = dly;
      next_shist  = shist;
      next_fix    = fix;
      next_acc    = acc && !ctrl.flush;
      if (in_valid) begin
         next_win = nwin;
         next_idx = (idx == LAST_POS) ? 6'h00 : idx + 6'h01;
         next_dly = {dly[31:0], in_data};
         if (idx >= PAY_POS && dstate != HUNT) begin
            next_shist = dsc[SCR_LEN-1:0];
            if (!ctrl.descr_dis) next_dly[7:0] = dsc[SCR_LEN+7:SCR_LEN];
         end
         unique case (dstate)
            HUNT: if (hdr_ok) begin
               next_dstate = PRESYNC;
               next_idx    = PAY_POS;
               next_run    = 3'h0;
            end
            PRESYNC: if (at_hdr) begin
               if (!hdr_ok) next_dstate = HUNT;
               else if (run == 3'(DELTA - 1)) begin
                  next_dstate = SYNC;
                  next_run    = 3'h0;
                  ev[F_DC]    = 1'b1;
               end else next_run = run + 3'h1;
            end
            SYNC: if (at_hdr) begin
               if (hdr_ok) next_run = 3'h0;
               else if (run == 3'(ALPHA - 1)) begin
                  next_dstate = HUNT;
                  ev[F_DC]    = 1'b1;
               end else next_run = run + 3'h1;
            end
         endcase
         if (at_hdr) begin
            next_fix = corr ? emask[39:8] : 32'h0;
            next_acc = cand && held < CW'(CELLS) && next_dstate == SYNC;
         end
      end
      if (sync_hdr) begin
         ev[F_CH] = corr;
         ev[F_UH] = unc;
         ev[F_OV] = cand && held >= CW'(CELLS);
         if (ctrl.hdr_pass) next_hstate = CORRECT;
         else next_hstate = hdr_ok ? CORRECT : DETECT;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dstate <= HUNT;
         hstate <= CORRECT;
         idx    <= 6'h00;
         run    <= 3'h0;
         win    <= 40'h0;
         dly    <= 40'h0;
         shist  <= '0;
         fix    <= 32'h0;
         acc    <= 1'b0;
      end else begin
         dstate <= next_dstate;
         hstate <= next_hstate;
         idx    <= next_idx;
         run    <= next_run;
         win    <= next_win;
         dly    <= next_dly;
         shist  <= next_shist;
         fix    <= next_fix;
         acc    <= next_acc;
      end
   end

   // Bytes reach the FIFO five bytes late so the header verdict is known
   assign dpos   = (idx >= PAY_POS) ? idx - PAY_POS : idx + TAIL_OFS;
   assign wr     = in_valid && acc && !ctrl.flush;
   assign commit = wr && dpos == LAST_POS;
   assign wbyte  = dly[39:32] ^ ((dpos < HCS_POS) ? fix[31 - 8*dpos -: 8] : 8'h00);
   assign rd     = rx_read && cnt != '0;
   assign pop    = rd && rbyte == LAST_POS;
   // The cell committing at a header decision already owns a slot
   assign held   = cnt + CW'(commit) - CW'(pop);
   assign rx_cell_avail = (cnt != '0);

   always_comb begin
      next_wptr  = commit ? ((wptr == PW'(CELLS - 1)) ? '0 : wptr + 1'b1) : wptr;
      next_rptr  = pop ? ((rptr == PW'(CELLS - 1)) ? '0 : rptr + 1'b1) : rptr;
      next_cnt   = cnt + CW'(commit) - CW'(pop);
      next_rbyte = rd ? (pop ? 6'h00 : rbyte + 6'h01) : rbyte;
      if (ctrl.flush) begin
         next_cnt   = '0;
         next_rptr  = next_wptr;
         next_rbyte = 6'h00;
      end
      next_rx_data  = rd ? mem[MW'(int'(rptr) * CELL_LEN + int'(rbyte))] : rx_data_out;
      next_rx_valid = rd && !ctrl.flush;
      next_rx_start = rd && !ctrl.flush && rbyte == 6'h00;
      next_rx_par   = ^next_rx_data ^ !ctrl.parity_type;
   end

   always_ff @(posedge aclk) begin
      if (wr) mem[MW'(int'(wptr) * CELL_LEN + int'(dpos))] <= wbyte;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wptr          <= '0;
         rptr          <= '0;
         cnt           <= '0;
         rbyte         <= 6'h00;
         rx_data_out   <= 8'h00;
         rx_data_valid <= 1'b0;
         rx_cell_start <= 1'b0;
         rx_parity_out <= 1'b0;
      end else begin
         wptr          <= next_wptr;
         rptr          <= next_rptr;
         cnt           <= next_cnt;
         rbyte         <= next_rbyte;
         rx_data_out   <= next_rx_data;
         rx_data_valid <= next_rx_valid;
         rx_cell_start <= next_rx_start;
         rx_parity_out <= next_rx_par;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_flush_empty;
      ctrl.flush |=> cnt == '0 && !rx_cell_avail;
   endproperty
   a_flush_empty: assert property (p_flush_empty) else $error("FIFO not empty under flush");
   property p_ooc_read;
      arvalid && arready && rsel[0] |=> rdata[B_OOC] == $past(ooc);
   endproperty
   a_ooc_read: assert property (p_ooc_read) else $error("Delineation status wrong");
   property p_nosync_drop;
      at_hdr && next_dstate != SYNC |=> !acc;
   endproperty
   a_nosync_drop: assert property (p_nosync_drop) else $error("Cell kept outside SYNC");
   property p_unc_drop;
      sync_hdr && unc && !ctrl.hdr_pass |=> !acc ##1 !wr;
   endproperty
   a_unc_drop: assert property (p_unc_drop) else $error("Errored cell not dropped");
   property p_pass_mode;
      ctrl.hdr_pass && sync_hdr |=> hstate == CORRECT;
   endproperty
   a_pass_mode: assert property (p_pass_mode) else $error("Left correction mode");
   property p_nocorr;
      sync_hdr && ctrl.corr_dis && !hdr_ok && !ctrl.hdr_pass |=> flags[F_UH] && !acc;
   endproperty
   a_nocorr: assert property (p_nocorr) else $error("Error corrected while disabled");
   property p_clear;
      rd_irq && ev == 4'h0 |=> flags == 4'h0 && !irq;
   endproperty
   a_clear: assert property (p_clear) else $error("Flags survive a status read");
   property p_sync_flag;
      dstate == PRESYNC && next_dstate == SYNC |=> flags[F_DC];
   endproperty
   a_sync_flag: assert property (p_sync_flag) else $error("No delineation flag");
   property p_parity;
      rx_data_valid |-> (^{rx_data_out, rx_parity_out}) == !$past(ctrl.parity_type);
   endproperty
   a_parity: assert property (p_parity) else $error("Bad receive parity");
   property p_irq_mask;
      flags[F_OV] && ien[0] |-> irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("Enabled event gives no interrupt");
   property p_fifo_bound;
      cnt <= CW'(CELLS);
   endproperty
   a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO holds too many cells");

   c_sync:    cover property (dstate == PRESYNC ##1 dstate == SYNC);
   c_commit:  cover property (commit);
   c_overrun: cover property (ev[F_OV]);
   c_correct: cover property (ev[F_CH]);
endmodule

// ===== verif/rcp_atm_reader.sv
// ATM layer side model that pulls bytes from the receive cell FIFO
module rcp_atm_reader (
   input  wire logic aclk,          // System clock
   input  wire logic aresetn,       // Synchronous reset, low
   input  wire logic stall,         // Hold off reads so the FIFO can fill
   input  wire logic rx_cell_avail, // Whole cell waiting
   output logic      rx_read        // Byte request
);
   timeunit 1ns;
   timeprecision 1ps;
   initial rx_read = 1'b0;
   // Request lags availability by a cycle; surplus requests are refused by the FIFO
   always @(posedge aclk) begin
      rx_read <= aresetn && !stall && rx_cell_avail;
   end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the receive cell processor
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rcp_pkg::*;

   typedef struct packed {
      logic [7:0]  ctl;
      logic [7:0]  pat;
      logic [7:0]  msk;
      logic [31:0] sh;
      logic [31:0] th;
      logic [1:0]  keep;
      logic [4:0]  flg;
   } rcp_row_s;

   localparam logic [11:0] A_CTL = {2'b00, IDX_CTRL, 2'b00};
   localparam logic [11:0] A_IRQ = {2'b00, IDX_IRQ, 2'b00};
   localparam logic [11:0] A_PAT = {2'b00, IDX_PAT, 2'b00};
   localparam logic [11:0] A_MSK = {2'b00, IDX_MSK, 2'b00};
   localparam logic [31:0] H1    = 32'h00100020;
   localparam logic [31:0] HI    = 32'hA000000E;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic        wvalid = 1'b0;
   logic [11:0] araddr = 12'h000;
   logic        arvalid = 1'b0;
   logic        in_valid = 1'b0;
   logic [7:0]  in_data = 8'h00;
   logic        stall = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, rx_read, rx_cell_avail;
   logic        rx_data_valid, rx_cell_start, rx_parity_out, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [7:0]  rx_data_out;
   logic [7:0]  ctl = 8'h04;
   logic [8:0]  exp_q [$];
   logic [8:0]  e;
   rcp_row_s    r;
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic [11:0] ra [5] = '{A_CTL, A_IRQ, A_PAT, A_MSK, 12'h150};
   logic [7:0]  rv [5] = '{8'h84, 8'h00, 8'h00, 8'h00, 8'h00};
   rcp_row_s    rows [14] = '{
      '{8'h06, 8'h00, 8'h00, H1, H1, 2'd1, 5'h00},
      '{8'h46, 8'h00, 8'h00, 32'h01234560, 32'h01234560, 2'd1, 5'h00},
      '{8'h06, 8'h00, 8'h00, HI, HI, 2'd0, 5'h00},
      '{8'h26, 8'h00, 8'h00, 32'h0, 32'h0, 2'd1, 5'h00},
      '{8'h06, 8'hA0, 8'hF0, HI, HI, 2'd0, 5'h00},
      '{8'h06, 8'h50, 8'hF0, HI, HI, 2'd1, 5'h00},
      '{8'h06, 8'h0E, 8'h0F, HI, HI, 2'd0, 5'h00},
      '{8'h06, 8'h01, 8'h01, HI, HI, 2'd1, 5'h00},
      '{8'h06, 8'h00, 8'h00, 32'h00110020, H1, 2'd1, 5'h08},
      '{8'h16, 8'h00, 8'h00, 32'h00110020, H1, 2'd0, 5'h04},
      '{8'h0E, 8'h00, 8'h00, 32'h00100320, H1, 2'd2, 5'h04},
      '{8'h06, 8'h00, 8'h00, 32'h00100320, H1, 2'd0, 5'h04},
      '{8'h04, 8'h00, 8'h00, H1, H1, 2'd1, 5'h00},
      '{8'h02, 8'h00, 8'h00, H1, H1, 2'd1, 5'h00}
   };

   rcp_receive_cell_processor DUT (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .in_valid(in_valid),
      .in_data(in_data), .rx_read(rx_read), .rx_cell_avail(rx_cell_avail),
      .rx_data_out(rx_data_out), .rx_data_valid(rx_data_valid), .rx_cell_start(rx_cell_start),
      .rx_parity_out(rx_parity_out), .irq(irq));

   rcp_atm_reader reader (.aclk(aclk), .aresetn(aresetn), .stall(stall),
      .rx_cell_avail(rx_cell_avail), .rx_read(rx_read));

   always #5 aclk = ~aclk;

   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic ok, input string m);
      checks_done++;
      if (!ok) begin
         err_total++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      if (a == A_CTL) ctl = d;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      check(bresp === er, "write response");
   endtask

   task automatic chk(input logic [11:0] a, input logic [7:0] ev, input logic [1:0] er = RESP_OKAY);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      check(rdata === {24'h000000, ev} && rresp === er, "register read");
   endtask

   function automatic logic [7:0] hec(input logic [31:0] d);
      logic [7:0] c = 8'h00;
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   // keep: 0 dropped, 1 delivered with true header, 2 delivered as sent
   task automatic send_cell(input logic [31:0] sh, input logic [31:0] th, input logic [1:0] keep);
      logic [7:0]  hcs, b, o;
      logic [31:0] eh;
      logic [42:0] s;
      hcs = hec(th) ^ (ctl[2] ? COSET : 8'h00);
      eh = (keep == 2'd2) ? sh : th;
      s = '0;
      for (int i = 0; i < CELL_LEN; i++) begin
         b = (i < 4) ? sh[31-8*i -: 8] : (i == 4) ? hcs : (th == 0) ? 8'h00 : 8'(i * 7 + 1);
         o = (i < 4) ? eh[31-8*i -: 8] : b;
         if (i > 4 && !ctl[1]) for (int k = 7; k >= 0; k--) begin
            o[k] = b[k] ^ s[42];
            s = {s[41:0], b[k]};
         end
         if (keep != 2'd0) exp_q.push_back({i == 0, o});
         in_data <= b;
         in_valid <= 1'b1;
         @(posedge aclk);
      end
      in_valid <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic drain();
      repeat (150) if (exp_q.size() != 0) @(posedge aclk);
      check(exp_q.size() == 0, "cell not delivered");
   endtask

   always @(negedge aclk) if (aresetn && rx_data_valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected byte");
      else begin
         e = exp_q.pop_front();
         check({rx_cell_start, rx_data_out} === e, "cell byte");
         check(rx_parity_out === (ctl[6] ? ^rx_data_out : ~^rx_data_out), "parity");
      end
   end

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end

   initial begin
      repeat (12) @(posedge aclk);
      check(rx_cell_avail === 1'b0 && irq === 1'b0 && rvalid === 1'b0, "reset outputs");
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (ra[i]) chk(ra[i], rv[i], (ra[i] == 12'h150) ? RESP_SLVERR : RESP_OKAY);
      wr(12'h150, 8'hFF, RESP_SLVERR);
      wr(A_PAT, 8'h5A);
      chk(A_PAT, 8'h5A);
      wr(A_MSK, 8'hA5);
      chk(A_MSK, 8'hA5);
      wr(A_CTL, 8'h06);
      wr(A_IRQ, 8'h80);
      repeat (9) send_cell(32'h0, 32'h0, 2'd0);
      chk(A_CTL, 8'h06);
      check(irq === 1'b1, "sync irq");
      chk(A_IRQ, 8'h90);
      check(irq === 1'b0, "irq after read");
      chk(A_IRQ, 8'h80);
      wr(A_IRQ, 8'h40);
      foreach (rows[n]) begin
         r = rows[n];
         wr(A_CTL, r.ctl);
         wr(A_PAT, r.pat);
         wr(A_MSK, r.msk);
         send_cell(r.sh, r.th, r.keep);
         wr(A_CTL, (r.ctl & 8'h42) | 8'h04);
         wr(A_PAT, 8'h00);
         wr(A_MSK, 8'h00);
         // Zero filler flushes the write pipeline and clears descrambler history
         send_cell(32'h0, 32'h0, 2'd0);
         drain();
         check(irq === (r.flg[3] | r.flg[2]), "header irq");
         chk(A_IRQ, {3'b010, r.flg});
      end
      wr(A_IRQ, 8'h20);
      stall <= 1'b1;
      repeat (6) send_cell(H1, H1, 2'd0);
      send_cell(32'h0, 32'h0, 2'd0);
      check(rx_cell_avail === 1'b1, "fifo holds cells");
      check(irq === 1'b1, "overrun irq");
      chk(A_IRQ, 8'h22);
      wr(A_CTL, 8'h07);
      @(posedge aclk);
      check(rx_cell_avail === 1'b0, "flush empties");
      send_cell(H1, H1, 2'd0);
      send_cell(32'h0, 32'h0, 2'd0);
      stall <= 1'b0;
      repeat (60) @(posedge aclk);
      check(rx_cell_avail === 1'b0, "writes while flushing");
      wr(A_CTL, 8'h06);
      send_cell(H1, H1, 2'd1);
      send_cell(32'h0, 32'h0, 2'd0);
      drain();
      wr(A_IRQ, 8'h80);
      repeat (7) send_cell(32'h00100023, H1, 2'd0);
      chk(A_CTL, 8'h86);
      check(irq === 1'b1, "loss irq");
      chk(A_IRQ, 8'h94);
      test_done();
   end
endmodule
